//--- logic/emb_block.sv
// embedded memory block: ram, rom and cam modes behind a register port
// assumes user logic drives inputs synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module emb_block (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic glob_clr,
  input wire logic in_clk_en,
  input wire logic out_clk_en,
  input wire logic in_clr,
  input wire logic out_clr,
  input wire emb_pkg::emb_in_s user_in,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [15:0] data_out,
  output logic match_out,
  output logic out_valid,
  output logic cam_busy,
  output logic irq
);
  import emb_pkg::*;

  // ==========================================================
  // functions
  function automatic logic [11:0] base_of(input logic [2:0] org,
                                          input logic [10:0] a);
    logic [2:0] k;
    logic [10:0] m;
    k = (org > 3'd4) ? 3'd4 : org;
    m = (11'h07f << k) | ((11'h001 << k) - 11'h001);
    base_of = {1'b0, a & m} << (3'd4 - k);
  endfunction

  function automatic logic [4:0] width_of(input logic [2:0] org);
    logic [2:0] k;
    k = (org > 3'd4) ? 3'd4 : org;
    width_of = 5'h10 >> k;
  endfunction

  function automatic logic [4:0] prio_enc(input logic [31:0] v);
    prio_enc = 5'h00;
    for (int i = 31; i >= 0; i--)
    begin
      if (v[i])
      begin
        prio_enc = 5'(i);
      end
    end
  endfunction

  // ==========================================================
  // clocks, enables and clears
  logic in_en;
  logic out_en;
  logic in_rst;
  logic out_rst;
  logic core_rst;
  assign in_en = clk_en & in_clk_en;
  assign out_en = clk_en & out_clk_en;
  // clears ored so any source resets asynchronously
  assign in_rst = sys_rst | glob_clr | in_clr;
  assign out_rst = sys_rst | glob_clr | out_clr;
  assign core_rst = sys_rst | glob_clr;

  // ==========================================================
  // register port
  emb_ctrl_s ctrl_q;
  logic [3:0] status_q;
  logic [3:0] status_d;
  logic [3:0] mask_q;
  logic [3:0] events;
  logic rd_status;

  assign rd_status = reg_rd & (reg_addr == OFF_STATUS);

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= emb_ctrl_s'(CTRL_RST[$bits(emb_ctrl_s)-1:0]);
      mask_q <= MASK_RST;
    end
    else if (clk_en && reg_wr)
    begin
      if (reg_addr == OFF_CTRL)
      begin
        ctrl_q <= emb_ctrl_s'(reg_wdata[$bits(emb_ctrl_s)-1:0]);
      end
      if (reg_addr == OFF_MASK)
      begin
        mask_q <= reg_wdata[3:0];
      end
    end
  end

  // set wins over the read clear
  always_comb
  begin
    status_d = (rd_status ? 4'h0 : status_q) | events;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      status_q <= 4'h0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      status_q <= status_d;
      irq <= |(status_d & mask_q);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        case (reg_addr)
          OFF_CTRL: reg_rdata <= 32'(ctrl_q);
          OFF_STATUS: reg_rdata <= {27'h0, cam_busy, status_q};
          OFF_MASK: reg_rdata <= {28'h0, mask_q};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // input registers, each one optionally bypassed
  emb_in_s in_q;
  emb_in_s in_s;

  always_ff @(posedge sys_clk or posedge in_rst)
  begin
    if (in_rst)
    begin
      in_q <= '0;
    end
    else if (in_en)
    begin
      in_q <= user_in;
    end
  end

  always_comb
  begin
    in_s.data = ctrl_q.byp_din ? user_in.data : in_q.data;
    in_s.dont_care = ctrl_q.byp_din ? user_in.dont_care : in_q.dont_care;
    in_s.wr_addr = ctrl_q.byp_wa ? user_in.wr_addr : in_q.wr_addr;
    in_s.rd_addr = ctrl_q.byp_ra ? user_in.rd_addr : in_q.rd_addr;
    in_s.write_strobe = ctrl_q.byp_we ? user_in.write_strobe
                                      : in_q.write_strobe;
    in_s.read_strobe = ctrl_q.byp_re ? user_in.read_strobe
                                     : in_q.read_strobe;
  end

  // ==========================================================
  // ram / rom core
  logic [MEM_BITS-1:0] mem_q;
  logic is_cam;
  logic wr_pulse;
  logic rd_req;
  logic hi_pend_q;
  logic [10:0] rd_a;
  logic [11:0] wbase;
  logic [11:0] rbase;
  logic [4:0] wid;
  logic [15:0] ram_word;

  assign is_cam = (ctrl_q.mode == MODE_CAM);
  // write pulse built here from the input-side strobe (registered or bypassed), the input clock enable and the mode
  assign wr_pulse = in_en & in_s.write_strobe
                    & (ctrl_q.mode inside {MODE_IO, MODE_SINGLE});
  // single port: write owns the cycle, read is dropped
  assign rd_req = in_s.read_strobe & ~hi_pend_q
                  & ~(ctrl_q.mode == MODE_SINGLE
                      && in_s.write_strobe);
  assign rd_a = (ctrl_q.mode == MODE_SINGLE) ? in_s.wr_addr
                                             : in_s.rd_addr;
  assign wid = width_of(ctrl_q.org);
  assign wbase = base_of(ctrl_q.org, in_s.wr_addr);
  assign rbase = base_of(ctrl_q.org, rd_a);

  always_comb
  begin
    ram_word = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      if (5'(i) < wid)
      begin
        ram_word[i] = mem_q[11'(rbase + 12'(i))];
      end
    end
  end

  // rom mode never writes, contents stay at the loaded pattern
  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      mem_q <= MEM_INIT;
    end
    else if (wr_pulse)
    begin
      for (int i = 0; i < 16; i++)
      begin
        if (5'(i) < wid)
        begin
          mem_q[11'(wbase + 12'(i))] <= in_s.data[i];
        end
      end
    end
  end

  // ==========================================================
  // cam storage and write sequence
  typedef enum logic [1:0] {C_IDLE, C_CLR, C_DATA, C_CARE} emb_cw_e;
  emb_cw_e cw_q;
  logic [31:0] cam_data_q [CAM_WORDS];
  logic [31:0] cam_care_q [CAM_WORDS];
  logic [31:0] cam_valid_q;
  logic [4:0] cw_ent_q;
  logic [31:0] cw_data_q;
  logic [31:0] cw_dc_q;
  logic cw_start;
  logic cw_done;
  logic refuse;

  assign cw_start = in_en & is_cam & in_s.write_strobe & (cw_q == C_IDLE);
  assign cw_done = in_en & ((cw_q == C_DATA && cw_dc_q == 32'h0)
                            || cw_q == C_CARE);
  assign refuse = in_en & in_s.write_strobe
                  & ((is_cam && cw_q != C_IDLE)
                     || ctrl_q.mode == MODE_ROM);

  always_ff @(posedge sys_clk or posedge in_rst)
  begin
    if (in_rst)
    begin
      cw_q <= C_IDLE;
      cw_ent_q <= 5'h00;
      cw_data_q <= 32'h0000_0000;
      cw_dc_q <= 32'h0000_0000;
      cam_busy <= 1'b0;
    end
    else if (in_en)
    begin
      case (cw_q)
        C_IDLE:
          if (cw_start)
          begin
            cw_q <= C_CLR;
            cw_ent_q <= in_s.wr_addr[4:0];
            cw_data_q <= in_s.data;
            cw_dc_q <= in_s.dont_care;
          end
        C_CLR: cw_q <= C_DATA;
        C_DATA: cw_q <= (cw_dc_q != 32'h0) ? C_CARE : C_IDLE;
        C_CARE: cw_q <= C_IDLE;
        default: cw_q <= C_IDLE;
      endcase
      cam_busy <= cw_start | (cw_q == C_CLR)
                  | (cw_q == C_DATA && cw_dc_q != 32'h0);
    end
  end

  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      cam_valid_q <= CAM_INIT_VALID;
      for (int e = 0; e < CAM_WORDS; e++)
      begin
        cam_data_q[e] <= CAM_INIT_DATA;
        cam_care_q[e] <= 32'hffff_ffff;
      end
    end
    else if (in_en)
    begin
      case (cw_q)
        C_CLR: cam_valid_q[cw_ent_q] <= 1'b0;
        C_DATA:
        begin
          cam_data_q[cw_ent_q] <= cw_data_q;
          cam_care_q[cw_ent_q] <= 32'hffff_ffff;
          cam_valid_q[cw_ent_q] <= (cw_dc_q == 32'h0);
        end
        C_CARE:
        begin
          cam_care_q[cw_ent_q] <= ~cw_dc_q;
          cam_valid_q[cw_ent_q] <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // cam search
  logic [31:0] hit;
  logic search;
  logic [15:0] hit_hi_q;
  logic hold_m_q;

  assign search = in_en & is_cam & rd_req;

  always_comb
  begin
    for (int e = 0; e < CAM_WORDS; e++)
    begin
      hit[e] = cam_valid_q[e]
               & (((in_s.data ^ cam_data_q[e]) & cam_care_q[e])
                  == 32'h0);
    end
  end

  always_ff @(posedge sys_clk or posedge in_rst)
  begin
    if (in_rst)
    begin
      hi_pend_q <= 1'b0;
      hit_hi_q <= 16'h0000;
      hold_m_q <= 1'b0;
    end
    else if (in_en)
    begin
      hi_pend_q <= search & ~ctrl_q.encoded;
      if (search)
      begin
        hit_hi_q <= hit[31:16];
        hold_m_q <= |hit;
      end
    end
  end

  // ==========================================================
  // read result, read register and output register
  emb_res_s core;
  emb_res_s pipe_q;

  always_comb
  begin
    core = '0;
    if (in_en && hi_pend_q)
    begin
      core = '{valid: 1'b1, match: hold_m_q, data: hit_hi_q};
    end
    else if (search)
    begin
      core.valid = 1'b1;
      core.match = |hit;
      core.data = ctrl_q.encoded ? {11'h000, prio_enc(hit)}
                                 : hit[15:0];
    end
    else if (in_en && rd_req)
    begin
      core = '{valid: 1'b1, match: 1'b0, data: ram_word};
    end
  end

  assign events = {refuse, cw_done,
                   search & ~(|hit), search & (|hit)};

  always_ff @(posedge sys_clk or posedge in_rst)
  begin
    if (in_rst)
    begin
      pipe_q <= '0;
    end
    else if (in_en)
    begin
      pipe_q <= core;
    end
  end

  // a result reaching a frozen output side is dropped
  always_ff @(posedge sys_clk or posedge out_rst)
  begin
    if (out_rst)
    begin
      data_out <= 16'h0000;
      match_out <= 1'b0;
      out_valid <= 1'b0;
    end
    else if (out_en)
    begin
      out_valid <= ctrl_q.byp_dout ? core.valid : pipe_q.valid;
      if (ctrl_q.byp_dout ? core.valid : pipe_q.valid)
      begin
        data_out <= ctrl_q.byp_dout ? core.data : pipe_q.data;
        match_out <= ctrl_q.byp_dout ? core.match : pipe_q.match;
      end
    end
  end

  // ==========================================================
  // checks
  a_out_frozen: assert property (@(posedge sys_clk) disable iff (out_rst)
    !out_en |=> $stable(data_out) && $stable(out_valid))
    else $error("output side moved while disabled");
  a_cam_two_cyc: assert property (@(posedge sys_clk) disable iff (in_rst)
    cw_start && in_s.dont_care == 32'h0 ##1 in_en[*2]
    |-> cw_done)
    else $error("cam write not done in two cycles");
  a_cam_three: assert property (@(posedge sys_clk) disable iff (in_rst)
    cw_start && in_s.dont_care != 32'h0 ##1 in_en[*3]
    |-> cw_q == C_CARE ##1 cw_q == C_IDLE)
    else $error("cam don't-care write not three cycles");
  a_match_flag: assert property (@(posedge sys_clk) disable iff (in_rst)
    search |-> core.match == (hit != 32'h0))
    else $error("match flag wrong");
  a_enc_addr: assert property (@(posedge sys_clk) disable iff (in_rst)
    search && ctrl_q.encoded && $onehot(hit)
    |-> hit[core.data[4:0]] && core.data[15:5] == 11'h0)
    else $error("encoded address wrong");
  a_unenc_halves: assert property (@(posedge sys_clk)
    disable iff (in_rst)
    search && !ctrl_q.encoded && in_clk_en && clk_en
    |=> hi_pend_q && hit_hi_q == $past(hit[31:16]))
    else $error("second half not queued");
  a_rom_fixed: assert property (@(posedge sys_clk) disable iff (core_rst)
    ctrl_q.mode == MODE_ROM |=> $stable(mem_q))
    else $error("rom contents changed");
  a_single_port: assert property (@(posedge sys_clk) disable iff (in_rst)
    ctrl_q.mode == MODE_SINGLE && in_s.write_strobe |-> !rd_req)
    else $error("single port overlap");
  a_wr_pulse: assert property (@(posedge sys_clk) disable iff (core_rst)
    $changed(mem_q) |-> $past(wr_pulse))
    else $error("memory changed without write pulse");
  a_status_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && events[ST_HIT] |=> status_q[ST_HIT])
    else $error("hit event lost");
  c_unenc: cover property (@(posedge sys_clk)
    search && !ctrl_q.encoded && $countones(hit) > 1);
  c_dc_write: cover property (@(posedge sys_clk) cw_q == C_CARE);
  c_ram_read: cover property (@(posedge sys_clk)
    out_valid && ctrl_q.mode == MODE_IO);
endmodule
`default_nettype wire

//--- logic/emb_pkg.sv
// package: constants, types and register map of the embedded memory block
// assumes one clock sys_clk at 20 MHz and a plain register port
`default_nettype none
package emb_pkg;
  localparam int unsigned MEM_BITS = 2048;
  localparam int unsigned CAM_WORDS = 32;
  localparam int unsigned CAM_WIDTH = 32;
  localparam int unsigned OUT_W = 16;
  localparam int unsigned CLK_NS = 50;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam int unsigned ST_HIT = 0;
  localparam int unsigned ST_MISS = 1;
  localparam int unsigned ST_WDONE = 2;
  localparam int unsigned ST_REFUSE = 3;
  // arbitrary contents loaded at configuration
  localparam logic [MEM_BITS-1:0] MEM_INIT = '0;
  localparam logic [CAM_WIDTH-1:0] CAM_INIT_DATA = 32'h0000_0000;
  localparam logic [CAM_WORDS-1:0] CAM_INIT_VALID = 32'h0000_0000;
  typedef enum logic [1:0] {
    MODE_IO, MODE_SINGLE, MODE_ROM, MODE_CAM
  } emb_mode_e;
  typedef struct packed {
    logic byp_re;
    logic byp_we;
    logic byp_wa;
    logic byp_ra;
    logic byp_dout;
    logic byp_din;
    logic encoded;
    logic [2:0] org;
    emb_mode_e mode;
  } emb_ctrl_s;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] dont_care;
    logic [10:0] wr_addr;
    logic [10:0] rd_addr;
    logic write_strobe;
    logic read_strobe;
  } emb_in_s;
  typedef struct packed {
    logic valid;
    logic match;
    logic [OUT_W-1:0] data;
  } emb_res_s;
endpackage
`default_nettype wire

//--- dv/emb_user_model.sv
// partner: user logic driving the block's input side
// assumes every call starts just after a rising edge of sys_clk
`timescale 1ns/10ps
`default_nettype none
module emb_user_model (
  input wire logic sys_clk,
  output var emb_pkg::emb_in_s user_in
);
  import emb_pkg::*;
  // ==========
  // one-cycle request
  initial user_in = '0;
  task automatic put(input logic ws, input logic rs, input logic [10:0] a,
    input logic [31:0] d, input logic [31:0] dc);
    user_in <= {d, dc, a, a, ws, rs};
    @(posedge sys_clk);
    // inverted so a stale word never passes for a live one
    user_in <= {~d, ~dc, ~a, ~a, 2'b00};
    @(posedge sys_clk);
  endtask
  // ==========
  // cam write, then hold off until the entry has landed
  task automatic cam_put(input logic [10:0] a, input logic [31:0] d,
    input logic [31:0] dc);
    put(1'b1, 1'b0, a, d, dc);
    repeat ((dc != '0) ? 3 : 2) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- dv/emb_block_bench.sv
// bench: self-checking run of the embedded memory block
// assumes the design package and the user-side partner model
`timescale 1ns/10ps
`default_nettype none
`define EMB_CHK(nm, e, s) \
  begin \
    checked++; \
    if ((s) !== (e)) \
    begin \
      miscompares++; \
      $display("Error %s expected %h seen %h", nm, e, s); \
    end \
  end
module emb_block_bench;
  import emb_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m;} emb_note_s;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic glob_clr = 1'b0;
  logic in_clk_en = 1'b1;
  logic out_clk_en = 1'b1;
  logic in_clr = 1'b0;
  logic out_clr = 1'b0;
  emb_in_s user_in;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] data_out;
  logic match_out, out_valid, cam_busy, irq;
  logic rd_d = 1'b0;
  logic saw_busy = 1'b0;
  int lat_cnt = 0;
  int got_lat = 0;
  int miscompares = 0;
  int checked = 0;
  logic [31:0] seed = 32'hba6f_307a;
  logic [31:0] a, d, m, w1, w2, w3;
  logic [31:0] byp[4] = '{32'h0000_0000, 32'h0000_0080, 32'h0000_0f40,
    32'h0000_0fc0};
  int lt[4] = '{3, 2, 2, 1};
  emb_note_s n;
  emb_note_s out_q[$];
  emb_note_s reg_q[$];

  always #25 sys_clk = ~sys_clk;

  emb_block i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .glob_clr(glob_clr), .in_clk_en(in_clk_en), .out_clk_en(out_clk_en),
    .in_clr(in_clr), .out_clr(out_clr), .user_in(user_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_out(data_out),
    .match_out(match_out), .out_valid(out_valid), .cam_busy(cam_busy),
    .irq(irq));
  emb_user_model i_user (.sys_clk(sys_clk), .user_in(user_in));

  // ==========
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic settle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic reg_w(input logic [7:0] ad, input logic [31:0] v);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic reg_r(input logic [7:0] ad, input logic [31:0] v,
    input logic [31:0] mk);
    reg_q.push_back('{v, mk});
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  // read or search, result noted first
  task automatic rd(input logic [10:0] ad, input logic [31:0] dd,
    input logic [31:0] e, input logic [31:0] mk);
    out_q.push_back('{e, mk});
    i_user.put(1'b0, 1'b1, ad, dd, '0);
  endtask
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========
  // result watcher
  always @(posedge sys_clk)
  begin
    rd_d <= reg_rd;
    lat_cnt <= user_in.read_strobe ? 1 : lat_cnt + 1;
    if (cam_busy === 1'b1)
      saw_busy <= 1'b1;
    if (rd_d)
    begin
      n = reg_q.pop_front();
      `EMB_CHK("reg_rdata", n.d, reg_rdata & n.m);
    end
    if (out_valid === 1'b1)
    begin
      got_lat <= lat_cnt;
      // an unexpected result can never match this note
      n = '{32'hdead_0000, 32'hffff_ffff};
      if (out_q.size() > 0)
        n = out_q.pop_front();
      `EMB_CHK("result", n.d, {15'h0, match_out, data_out} & n.m);
    end
  end

  initial
  begin
    settle(100000);
    miscompares++;
    print_verdict();
  end

  // ==========
  // main sequence
  initial
  begin
    settle(6);
    sys_rst <= 1'b0;
    settle(1);
    reg_r(OFF_CTRL, CTRL_RST, '1);
    reg_r(OFF_MASK, 32'(MASK_RST), '1);
    reg_r(OFF_STATUS, 32'h0, '1);
    reg_w(8'h0c, 32'hffff_ffff);
    reg_r(8'h0c, 32'h0, '1);
    for (int o = 0; o < 5; o++)
    begin
      reg_w(OFF_CTRL, 32'(o) << 2);
      // upper half only, so the low words used later stay at the init value
      a = (rnd() & ((32'd64 << o) - 1)) | (32'd64 << o);
      d = rnd();
      m = (32'd1 << (16 >> o)) - 1;
      i_user.put(1'b1, 1'b0, a[10:0], d, '0);
      rd(a[10:0], 32'h0, d & m, m);
    end
    reg_w(OFF_CTRL, 32'h0);
    i_user.put(1'b1, 1'b0, 11'h005, d, '0);
    for (int i = 0; i < 4; i++)
    begin
      reg_w(OFF_CTRL, byp[i]);
      rd(11'h005, 32'h0, d & 32'hffff, 32'hffff);
      settle(4);
      `EMB_CHK("latency", lt[i], got_lat);
    end
    reg_w(OFF_CTRL, 32'h1);
    i_user.put(1'b1, 1'b0, 11'h009, ~d, '0);
    rd(11'h009, 32'h0, ~d & 32'hffff, 32'hffff);
    i_user.put(1'b1, 1'b1, 11'h00a, d, '0);
    settle(4);
    reg_w(OFF_CTRL, 32'h2);
    i_user.put(1'b1, 1'b0, 11'h003, 32'hffff_ffff, '0);
    rd(11'h003, 32'h0, 32'(MEM_INIT[48 +: 16]), 32'hffff);
    reg_r(OFF_STATUS, 32'h8, 32'h8);
    reg_w(OFF_CTRL, 32'h23);
    rd(0, CAM_INIT_DATA, {15'h0, |CAM_INIT_VALID, 16'h0}, 32'h1_0000);
    w1 = rnd();
    w2 = rnd();
    w3 = rnd();
    i_user.cam_put(11'd12, w1, '0);
    `EMB_CHK("busy seen", 1'b1, saw_busy);
    // busy drops on the edge the task returns at, look one edge later
    settle(1);
    `EMB_CHK("busy", 1'b0, cam_busy);
    rd(0, w1, 32'h1_000c, 32'h1_001f);
    rd(0, ~w1, 32'h0, 32'h1_0000);
    settle(4);
    `EMB_CHK("irq masked", 1'b0, irq);
    reg_w(OFF_MASK, 32'h1);
    settle(2);
    `EMB_CHK("irq", 1'b1, irq);
    reg_r(OFF_STATUS, 32'h3, 32'h3);
    settle(2);
    `EMB_CHK("irq cleared", 1'b0, irq);
    i_user.cam_put(11'd20, w2, 32'h0000_00ff);
    rd(0, w2 ^ 32'h5a, 32'h1_0014, 32'h1_001f);
    rd(0, w2 ^ 32'h100, 32'h0, 32'h1_0000);
    reg_w(OFF_CTRL, 32'h3);
    i_user.cam_put(11'd3, w3, '0);
    i_user.cam_put(11'd27, w3, '0);
    out_q.push_back('{32'h1_0008, '1});
    rd(0, w3, 32'h1_0800, '1);
    settle(6);
    // result must vanish while the output side is held
    out_clk_en <= 1'b0;
    i_user.put(1'b0, 1'b1, 0, w3, '0);
    settle(6);
    out_clk_en <= 1'b1;
    in_clr <= 1'b1;
    settle(1);
    in_clr <= 1'b0;
    out_clr <= 1'b1;
    settle(1);
    `EMB_CHK("out clear", 17'h0, {match_out, data_out});
    out_clr <= 1'b0;
    out_q.push_back('{32'h1_0008, '1});
    rd(0, w3, 32'h1_0800, '1);
    settle(6);
    glob_clr <= 1'b1;
    settle(1);
    `EMB_CHK("glob clear", 18'h0, {cam_busy, match_out, data_out});
    glob_clr <= 1'b0;
    reg_r(OFF_CTRL, 32'h3, '1);
    settle(4);
    `EMB_CHK("pending", 0, out_q.size());
    print_verdict();
  end
endmodule
`default_nettype wire
